//--- verilog/pcdm_pin_mux.sv
// Pin function multiplexer for ports C and D, input routing, port A wake.
// Assumes pins arrive asynchronously; peripheral signals are on clk.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pcdm_pin_mux
   import pcdm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire pcdm_bus_t bus,
   output logic [7:0] rdata,
   input wire logic spi_master_mode,
   input wire logic serial_module_enable,
   input wire logic chip_select_enable,
   input wire logic sleep_mode,
   input wire pcdm_periph_out_t periph_out,
   output pcdm_periph_in_t periph_in,
   output pcdm_analog_t analog_en,
   input wire logic [7:0] pa_in,
   input wire logic [7:0] pb_in,
   input wire logic [6:0] pc_in,
   input wire logic [3:0] pd_in,
   output logic [7:0] pa_out,
   output logic [7:0] pa_oe_n,
   output logic [6:0] pc_out,
   output logic [6:0] pc_oe_n,
   output logic [3:0] pd_out,
   output logic [3:0] pd_oe_n,
   output logic wake_up
);
   logic [7:0] pcsel_lo_reg;
   logic [7:0] pcsel_hi_reg;
   logic [7:0] pdsel_reg;
   logic [7:0] insel_reg;
   logic [7:0] pa_data_reg;
   logic [7:0] pa_ctrl_reg;
   logic [7:0] pc_data_reg;
   logic [7:0] pc_ctrl_reg;
   logic [7:0] pd_data_reg;
   logic [7:0] pd_ctrl_reg;
   logic [7:0] pa_wake_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic wake_reg;

   // Two-flop synchronisers for all pins
   logic [26:0] pin_meta_reg;
   logic [26:0] pin_sync_reg;
   logic [7:0] pa_prev_reg;
   wire [26:0] pin_raw = {pd_in, pc_in, pb_in, pa_in};
   wire [7:0] pa_s = pin_sync_reg[7:0];
   wire [7:0] pb_s = pin_sync_reg[15:8];
   wire [6:0] pc_s = pin_sync_reg[22:16];
   wire [3:0] pd_s = pin_sync_reg[26:23];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Idle high like the edge history, so release shows no false fall
         pin_meta_reg <= '1;
         pin_sync_reg <= '1;
         pa_prev_reg <= 8'hff;
      end else begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
         pa_prev_reg <= pa_s;
      end
   end

   // Register write decode
   wire wr_pcsel_lo = bus.wr && (bus.addr == PCDM_ADDR_PCSEL_LO);
   wire wr_pcsel_hi = bus.wr && (bus.addr == PCDM_ADDR_PCSEL_HI);
   wire wr_pdsel = bus.wr && (bus.addr == PCDM_ADDR_PDSEL);
   wire wr_insel = bus.wr && (bus.addr == PCDM_ADDR_INSEL);
   wire wr_pa_data = bus.wr && (bus.addr == PCDM_ADDR_PA_DATA);
   wire wr_pa_ctrl = bus.wr && (bus.addr == PCDM_ADDR_PA_CTRL);
   wire wr_pc_data = bus.wr && (bus.addr == PCDM_ADDR_PC_DATA);
   wire wr_pc_ctrl = bus.wr && (bus.addr == PCDM_ADDR_PC_CTRL);
   wire wr_pd_data = bus.wr && (bus.addr == PCDM_ADDR_PD_DATA);
   wire wr_pd_ctrl = bus.wr && (bus.addr == PCDM_ADDR_PD_CTRL);
   wire wr_pa_wake = bus.wr && (bus.addr == PCDM_ADDR_PA_WAKE);

   // Select registers clear to zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pcsel_lo_reg <= PCDM_SEL_RESET;
         pcsel_hi_reg <= PCDM_SEL_RESET;
         pdsel_reg <= PCDM_SEL_RESET;
         insel_reg <= PCDM_SEL_RESET;
      end else begin
         if (wr_pcsel_lo) pcsel_lo_reg <= bus.wdata;
         if (wr_pcsel_hi) pcsel_hi_reg <= bus.wdata & PCDM_PCSEL_HI_MASK;
         if (wr_pdsel) pdsel_reg <= bus.wdata;
         if (wr_insel) insel_reg <= bus.wdata;
      end
   end

   // Port data and control start all ones: inputs, high data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pa_data_reg <= PCDM_PORT_RESET;
         pa_ctrl_reg <= PCDM_PORT_RESET;
         pc_data_reg <= PCDM_PORT_RESET;
         pc_ctrl_reg <= PCDM_PORT_RESET;
         pd_data_reg <= PCDM_PORT_RESET;
         pd_ctrl_reg <= PCDM_PORT_RESET;
         pa_wake_reg <= PCDM_WAKE_RESET;
      end else begin
         // Whole-byte writes only; bit ops are software RMW
         if (wr_pa_data) pa_data_reg <= bus.wdata;
         if (wr_pa_ctrl) pa_ctrl_reg <= bus.wdata;
         if (wr_pc_data) pc_data_reg <= bus.wdata;
         if (wr_pc_ctrl) pc_ctrl_reg <= bus.wdata;
         if (wr_pd_data) pd_data_reg <= bus.wdata;
         if (wr_pd_ctrl) pd_ctrl_reg <= bus.wdata;
         if (wr_pa_wake) pa_wake_reg <= bus.wdata;
      end
   end

   // Read mux; data registers read back the written value, pin levels have their own addresses
   always_comb begin
      if (!bus.rd) rdata_next = rdata_reg;
      else if (bus.addr == PCDM_ADDR_PCSEL_LO) rdata_next = pcsel_lo_reg;
      else if (bus.addr == PCDM_ADDR_PCSEL_HI) rdata_next = pcsel_hi_reg & PCDM_PCSEL_HI_MASK;
      else if (bus.addr == PCDM_ADDR_PDSEL) rdata_next = pdsel_reg;
      else if (bus.addr == PCDM_ADDR_INSEL) rdata_next = insel_reg;
      else if (bus.addr == PCDM_ADDR_PA_DATA) rdata_next = pa_data_reg;
      else if (bus.addr == PCDM_ADDR_PA_CTRL) rdata_next = pa_ctrl_reg;
      else if (bus.addr == PCDM_ADDR_PC_DATA) rdata_next = pc_data_reg;
      else if (bus.addr == PCDM_ADDR_PC_CTRL) rdata_next = pc_ctrl_reg;
      else if (bus.addr == PCDM_ADDR_PD_DATA) rdata_next = pd_data_reg;
      else if (bus.addr == PCDM_ADDR_PD_CTRL) rdata_next = pd_ctrl_reg;
      else if (bus.addr == PCDM_ADDR_PA_WAKE) rdata_next = pa_wake_reg;
      else if (bus.addr == PCDM_ADDR_PA_PIN) rdata_next = pa_s;
      else if (bus.addr == PCDM_ADDR_PC_PIN) rdata_next = {1'b0, pc_s};
      else if (bus.addr == PCDM_ADDR_PD_PIN) rdata_next = {4'h0, pd_s};
      else rdata_next = PCDM_UNMAPPED_DATA;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) rdata_reg <= PCDM_UNMAPPED_DATA;
      else rdata_reg <= rdata_next;
   end
   assign rdata = rdata_reg;

   // Field extraction
   wire [1:0] f_pc3 = pcsel_lo_reg[7:6];
   wire [1:0] f_pc2 = pcsel_lo_reg[5:4];
   wire [1:0] f_pc1 = pcsel_lo_reg[3:2];
   wire [1:0] f_pc0 = pcsel_lo_reg[1:0];
   wire [1:0] f_pc6 = pcsel_hi_reg[5:4];
   wire [1:0] f_pc5 = pcsel_hi_reg[3:2];
   wire [1:0] f_pc4 = pcsel_hi_reg[1:0];
   wire [1:0] f_pd3 = pdsel_reg[7:6];
   wire [1:0] f_pd2 = pdsel_reg[5:4];
   wire [1:0] f_pd1 = pdsel_reg[3:2];
   wire [1:0] f_pd0 = pdsel_reg[1:0];
   wire [1:0] f_sdi = insel_reg[7:6];
   wire [1:0] f_cs = insel_reg[5:4];
   wire [1:0] f_clk = insel_reg[3:2];
   wire [1:0] f_rx = insel_reg[1:0];

   // Peripheral output claims per pin
   wire pc3_sdo = (f_pc3 == PCDM_C10);
   wire pc3_cmp = (f_pc3 == PCDM_C11);
   wire pc2_ptm = (f_pc2 == PCDM_C01);
   wire pc1_sdo = (f_pc1 == PCDM_C01);
   wire pc1_osc = (f_pc1 == PCDM_C10);
   wire pc0_cs = (f_pc0 == PCDM_C01);
   wire pc0_osc = (f_pc0 == PCDM_C10);
   wire pc0_stm = (f_pc0 == PCDM_C11);
   wire pd0_cmp = (f_pd0 == PCDM_C01);
   wire pd0_clk = (f_pd0 == PCDM_C10);

   wire master_on = spi_master_mode && serial_module_enable;
   wire master_cs = master_on && chip_select_enable;

   // Peripheral drives replace port data; oscillator pins leave digital I/O
   wire [6:0] pc_claim = {1'b0, 1'b0, 1'b0, pc3_sdo | pc3_cmp, pc2_ptm,
                          pc1_sdo | pc1_osc, pc0_cs | pc0_osc | pc0_stm};
   wire [6:0] pc_sig = {1'b0, 1'b0, 1'b0,
                        pc3_cmp ? periph_out.comparator1_output : periph_out.spi_data_out,
                        periph_out.periodic_timer1_output,
                        periph_out.spi_data_out,
                        pc0_stm ? periph_out.standard_timer1_output : periph_out.spi_cs_out};
   wire [6:0] pc_osc = {5'h00, pc1_osc, pc0_osc};
   wire [3:0] pd_claim = {3'h0, pd0_cmp | pd0_clk};
   wire [3:0] pd_sig = {3'h0,
                        pd0_cmp ? periph_out.comparator0_output : periph_out.spi_clk_out};

   // Clock output follows master mode on PA4; chip select on PA3 also needs chip select enabled
   wire pa_cs_drv = master_cs;
   wire pa_clk_drv = master_on;

   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_pc
         wire drive = pc_claim[gi] && !pc_osc[gi];
         assign pc_out[gi] = drive ? pc_sig[gi] : pc_data_reg[gi];
         assign pc_oe_n[gi] = pc_osc[gi] ? 1'b1 : (drive ? 1'b0 : pc_ctrl_reg[gi]);
      end
      for (gi = 0; gi < 4; gi++) begin : g_pd
         assign pd_out[gi] = pd_claim[gi] ? pd_sig[gi] : pd_data_reg[gi];
         assign pd_oe_n[gi] = pd_claim[gi] ? 1'b0 : pd_ctrl_reg[gi];
      end
      for (gi = 0; gi < 8; gi++) begin : g_pa
         wire cs_pin = (gi == 3) && pa_cs_drv;
         wire clk_pin = (gi == 4) && pa_clk_drv;
         assign pa_out[gi] = cs_pin ? periph_out.spi_cs_out :
                             (clk_pin ? periph_out.spi_clk_out : pa_data_reg[gi]);
         assign pa_oe_n[gi] = (cs_pin || clk_pin) ? 1'b0 : pa_ctrl_reg[gi];
      end
   endgenerate

   // Analog and oscillator connections
   assign analog_en.comparator0_negative_input = (f_pc6 == PCDM_C01);
   assign analog_en.comparator1_positive_input = (f_pc5 == PCDM_C01);
   assign analog_en.comparator1_negative_input = (f_pc4 == PCDM_C01);
   assign analog_en.opamp0_positive_input = (f_pd3 == PCDM_C01);
   assign analog_en.opamp0_negative_input = (f_pd2 == PCDM_C01);
   assign analog_en.comparator0_positive_input = (f_pd1 == PCDM_C01);
   assign analog_en.oscillator_pin_one = pc0_osc;
   assign analog_en.oscillator_pin_two = pc1_osc;

   // Input routing; in master mode the clock source field is bypassed, and the chip-select field too with chip select enabled
   assign periph_in.spi_data_in = f_sdi[1] ? pb_s[6] : pa_s[1];
   assign periph_in.spi_cs_in = master_cs ? pa_s[3] & pc_s[0] :
                                (f_cs[1] ? pc_s[0] : pa_s[3]);
   assign periph_in.spi_clk_in = master_on ? pd_s[0] :
                                 (f_clk[1] ? pa_s[4] : pd_s[0]);
   assign periph_in.uart_rx_in = (f_rx == PCDM_C01) ? pa_s[0] :
                                 ((f_rx == PCDM_C10) ? pa_s[5] : pb_s[6]);
   assign periph_in.standard_timer1_capture_input = pc_s[2];
   assign periph_in.external_reset_input = pc_s[2];
   assign periph_in.standard_timer1_clock_input = pc_s[1];

   // Port A falling edge wakes a sleeping device
   wire [7:0] pa_fall = pa_prev_reg & ~pa_s;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) wake_reg <= 1'b0;
      else wake_reg <= sleep_mode && |(pa_fall & pa_wake_reg);
   end
   assign wake_up = wake_reg;
endmodule : pcdm_pin_mux
`default_nettype wire

//--- verilog/pcdm_pkg.sv
// Constants and types for the port C/D pin function multiplexer.
// Assumes a plain register port with one-cycle strobes on clk.
// Behaviour
// - PC3 field selects SPI out or comparator1
// - PC2 code 01 drives periodic timer1
// - PC1 selects SPI out or oscillator two
// - PC0 selects chip select, oscillator, timer
// - Select-high bits 7..6 read zero
// - PC5 code 01 connects comparator1 positive
// - PC4 code 01 connects comparator1 negative
// - PD3 code 01 connects opamp0 positive
// - PD2 code 01 connects opamp0 negative
// - PD1 code 01 connects comparator0 positive
// - PD0 selects comparator0 out or clock
// - Data-in source PA1 or PB6
// - Chip-select source PA3 or PC0
// - Clock source PD0 or PA4
// - Receive source PB6, PA0 or PA5
// - Master mode overrides chip-select/clock sources; the chip-select override also needs chip select enabled
// - Data and control registers reset ones
// - Output drives high before data write
// - Bit operations are whole-byte read-modify-write
// - Port A falling edge wakes device
// - Select registers reset zero, read/write
package pcdm_pkg;
   localparam logic [3:0] PCDM_ADDR_PCSEL_LO = 4'h0;
   localparam logic [3:0] PCDM_ADDR_PCSEL_HI = 4'h1;
   localparam logic [3:0] PCDM_ADDR_PDSEL = 4'h2;
   localparam logic [3:0] PCDM_ADDR_INSEL = 4'h3;
   localparam logic [3:0] PCDM_ADDR_PA_DATA = 4'h4;
   localparam logic [3:0] PCDM_ADDR_PA_CTRL = 4'h5;
   localparam logic [3:0] PCDM_ADDR_PC_DATA = 4'h6;
   localparam logic [3:0] PCDM_ADDR_PC_CTRL = 4'h7;
   localparam logic [3:0] PCDM_ADDR_PD_DATA = 4'h8;
   localparam logic [3:0] PCDM_ADDR_PD_CTRL = 4'h9;
   localparam logic [3:0] PCDM_ADDR_PA_WAKE = 4'ha;
   localparam logic [3:0] PCDM_ADDR_PA_PIN = 4'hb;
   localparam logic [3:0] PCDM_ADDR_PC_PIN = 4'hc;
   localparam logic [3:0] PCDM_ADDR_PD_PIN = 4'hd;
   localparam logic [7:0] PCDM_SEL_RESET = 8'h00;
   localparam logic [7:0] PCDM_PORT_RESET = 8'hff;
   localparam logic [7:0] PCDM_WAKE_RESET = 8'h00;
   localparam logic [7:0] PCDM_PCSEL_HI_MASK = 8'h3f;
   localparam logic [7:0] PCDM_UNMAPPED_DATA = 8'h00;
   localparam logic [1:0] PCDM_C00 = 2'h0;
   localparam logic [1:0] PCDM_C01 = 2'h1;
   localparam logic [1:0] PCDM_C10 = 2'h2;
   localparam logic [1:0] PCDM_C11 = 2'h3;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pcdm_bus_t;

   // Peripheral outputs that may claim a pin
   typedef struct packed {
      logic spi_data_out;
      logic spi_cs_out;
      logic spi_clk_out;
      logic comparator1_output;
      logic comparator0_output;
      logic periodic_timer1_output;
      logic standard_timer1_output;
   } pcdm_periph_out_t;

   // Pin levels handed to peripherals
   typedef struct packed {
      logic spi_data_in;
      logic spi_cs_in;
      logic spi_clk_in;
      logic uart_rx_in;
      logic standard_timer1_capture_input;
      logic standard_timer1_clock_input;
      logic external_reset_input;
   } pcdm_periph_in_t;

   // Analog and oscillator connection enables
   typedef struct packed {
      logic comparator0_negative_input;
      logic comparator1_positive_input;
      logic comparator1_negative_input;
      logic opamp0_positive_input;
      logic opamp0_negative_input;
      logic comparator0_positive_input;
      logic oscillator_pin_one;
      logic oscillator_pin_two;
   } pcdm_analog_t;
endpackage : pcdm_pkg

//--- dv/pcdm_pin_mux_checker.sv
// Port-level checks for the pin function mux.
// Bound to pcdm_pin_mux; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pcdm_pin_mux_checker
   import pcdm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire pcdm_bus_t bus,
   input wire logic [7:0] rdata,
   input wire pcdm_periph_out_t periph_out,
   input wire pcdm_periph_in_t periph_in,
   input wire pcdm_analog_t analog_en,
   input wire logic [7:0] pa_in,
   input wire logic [7:0] pb_in,
   input wire logic [6:0] pc_out,
   input wire logic [6:0] pc_oe_n,
   input wire logic [3:0] pd_out,
   input wire logic [3:0] pd_oe_n
);
   logic [3:0][7:0] sel_reg;
   wire logic [7:0] wmask = (bus.addr == PCDM_ADDR_PCSEL_HI) ? PCDM_PCSEL_HI_MASK : 8'hff;
   wire logic [7:0] sel_rd = sel_reg[bus.addr[1:0]];
   wire logic [1:0] rx_sel = sel_reg[3][1:0];
   wire logic rx_exp = rx_sel == 2'h1 ? pa_in[0] : (rx_sel == 2'h2 ? pa_in[5] : pb_in[6]);
   wire logic [7:0] ana_exp = {sel_reg[1][5:4] == 2'h1, sel_reg[1][3:2] == 2'h1,
      sel_reg[1][1:0] == 2'h1, sel_reg[2][7:6] == 2'h1, sel_reg[2][5:4] == 2'h1,
      sel_reg[2][3:2] == 2'h1, sel_reg[0][1:0] == 2'h2, sel_reg[0][3:2] == 2'h2};
   // Shadow of the four select registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         sel_reg <= '0;
      else if (bus.wr && bus.addr < 4'h4)
         sel_reg[bus.addr[1:0]] <= bus.wdata & wmask;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_pins_still;
      ($stable(pa_in) && $stable(pb_in) && $stable(sel_reg[3])) [*4];
   endsequence
   a_pc3_func: assert property (sel_reg[0][7] |-> !pc_oe_n[3] && pc_out[3] ==
      (sel_reg[0][6] ? periph_out.comparator1_output : periph_out.spi_data_out))
      else $error("pc3 function output wrong");
   a_pc2_timer: assert property (sel_reg[0][5:4] == 2'h1 |-> !pc_oe_n[2] &&
      pc_out[2] == periph_out.periodic_timer1_output) else $error("pc2 timer output wrong");
   a_pc0_timer: assert property (sel_reg[0][1:0] == 2'h3 |-> !pc_oe_n[0] &&
      pc_out[0] == periph_out.standard_timer1_output) else $error("pc0 timer output wrong");
   a_pd0_cmp_out: assert property (sel_reg[2][1:0] == 2'h1 |-> !pd_oe_n[0] &&
      pd_out[0] == periph_out.comparator0_output) else $error("pd0 comparator output wrong");
   a_analog_conn: assert property (analog_en == ana_exp)
      else $error("analog connect wrong");
   a_sel_readback: assert property (bus.rd && bus.addr < 4'h4 |=> rdata == $past(sel_rd))
      else $error("select readback wrong");
   a_hi_top_zero: assert property (bus.rd && bus.addr == PCDM_ADDR_PCSEL_HI |=>
      rdata[7:6] == 2'h0) else $error("unused select bits not zero");
   a_reset_idle: assert property ($rose(rst_n) |-> &pc_oe_n && &pd_oe_n &&
      &pc_out && &pd_out) else $error("ports not idle high after reset");
   a_rx_route: assert property (s_pins_still |-> periph_in.uart_rx_in == rx_exp)
      else $error("receive source wrong");
   a_sdi_route: assert property (s_pins_still |-> periph_in.spi_data_in ==
      (sel_reg[3][7] ? pb_in[6] : pa_in[1])) else $error("data-in source wrong");
endmodule : pcdm_pin_mux_checker
`default_nettype wire

//--- dv/pcdm_far_side.sv
// Far side: toggling peripheral outputs and package pins.
// Driven pins follow the block, released pins take the bench level.
`timescale 1ns/1ps
`default_nettype none
module pcdm_far_side
   import pcdm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [26:0] ext_lvl,
   input wire logic [18:0] drv_out,
   input wire logic [18:0] drv_oe_n,
   output wire pcdm_periph_out_t periph_out,
   output wire logic [7:0] pa_in,
   output wire logic [7:0] pb_in,
   output wire logic [6:0] pc_in,
   output wire logic [3:0] pd_in
);
   logic [6:0] tog_reg;
   wire logic [18:0] ext_drv = {ext_lvl[26:19], ext_lvl[10:0]};
   // Each output flips every cycle so a wrong route shows at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         tog_reg <= 7'h55;
      else
         tog_reg <= ~tog_reg;
   end
   assign periph_out = tog_reg;
   assign {pa_in, pc_in, pd_in} = (drv_oe_n & ext_drv) | (~drv_oe_n & drv_out);
   assign pb_in = ext_lvl[18:11];
endmodule : pcdm_far_side
`default_nettype wire

//--- dv/pcdm_pin_mux_test.sv
// Self-checking bench for the port C/D pin function mux.
// Uses the far-side model; the checker is bound below.
`timescale 1ns/1ps
`default_nettype none
module pcdm_pin_mux_test
   import pcdm_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic master = 1'b0;
   logic sleep_mode = 1'b0;
   logic [26:0] ext_lvl = '0;
   pcdm_bus_t bus = '0;
   int err_total = 0;
   int check_count = 0;
   logic [7:0] rdata, pa_out, pa_oe_n, pa_in, pb_in;
   logic [6:0] pc_out, pc_oe_n, pc_in;
   logic [3:0] pd_out, pd_oe_n, pd_in;
   logic wake_up;
   pcdm_periph_out_t periph_out;
   pcdm_periph_in_t periph_in;
   pcdm_analog_t analog_en;
   initial forever #20 clk = ~clk;
   pcdm_pin_mux i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .spi_master_mode(master), .serial_module_enable(master), .chip_select_enable(master),
      .sleep_mode(sleep_mode), .periph_out(periph_out), .periph_in(periph_in),
      .analog_en(analog_en), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in), .pd_in(pd_in),
      .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pc_out(pc_out), .pc_oe_n(pc_oe_n),
      .pd_out(pd_out), .pd_oe_n(pd_oe_n), .wake_up(wake_up));
   pcdm_far_side i_far (.clk(clk), .rst_n(rst_n), .ext_lvl(ext_lvl),
      .drv_out({pa_out, pc_out, pd_out}), .drv_oe_n({pa_oe_n, pc_oe_n, pd_oe_n}),
      .periph_out(periph_out), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in), .pd_in(pd_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic [3:0] a, input logic [7:0] d, input logic w);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk);
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
   endtask : acc
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      acc(a, 8'h00, 1'b0);
      #1 chk(rdata, exp);
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic t_reset;
      for (int a = 0; a < 11; a++) rd(4'(a), (a > 3 && a < 10) ? 8'hff : 8'h00);
      rd(4'he, PCDM_UNMAPPED_DATA);
      acc(PCDM_ADDR_PC_CTRL, 8'h00, 1'b1);
      #1 chk({1'b0, pc_oe_n}, 8'h00);
      chk({1'b0, pc_out}, 8'h7f);
   endtask : t_reset
   task automatic t_readback;
      for (int a = 0; a < 4; a++) begin
         acc(4'(a), 8'hff, 1'b1);
         rd(4'(a), a == 1 ? PCDM_PCSEL_HI_MASK : 8'hff);
         acc(4'(a), 8'h00, 1'b1);
         rd(4'(a), 8'h00);
      end
   endtask : t_readback
   task automatic t_codes;
      logic [1:0] c;
      acc(PCDM_ADDR_PC_DATA, 8'h00, 1'b1);
      acc(PCDM_ADDR_PD_DATA, 8'h00, 1'b1);
      acc(PCDM_ADDR_PD_CTRL, 8'h00, 1'b1);
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         for (int a = 0; a < 3; a++) acc(4'(a), {4{c}}, 1'b1);
         #1 chk(pc_out[3], c == 2'h3 ? periph_out.comparator1_output
            : c == 2'h2 && periph_out.spi_data_out);
         chk(pc_out[2], c == 2'h1 && periph_out.periodic_timer1_output);
         chk(pc_out[1] | c == 2'h2, c == 2'h1 ? periph_out.spi_data_out : c == 2'h2);
         chk(pc_oe_n[3:1], {2'b00, c == 2'h2});
         if (c != 2'h1) chk(pc_out[0] | c == 2'h2, c == 2'h2 || (c == 2'h3
            && periph_out.standard_timer1_output));
         if (c != 2'h2) chk(pd_out[0], c == 2'h1 && periph_out.comparator0_output);
         chk(analog_en, {{6{c == 2'h1}}, c == 2'h2, c == 2'h2});
      end
      for (int a = 0; a < 3; a++) acc(4'(a), 8'h00, 1'b1);
      acc(PCDM_ADDR_PC_CTRL, 8'hff, 1'b1);
      acc(PCDM_ADDR_PD_CTRL, 8'hff, 1'b1);
   endtask : t_codes
   task automatic t_routes(input logic [26:0] lvl);
      logic [1:0] c;
      @(posedge clk);
      ext_lvl <= lvl;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         acc(PCDM_ADDR_INSEL, {4{c}}, 1'b1);
         cyc(4);
         chk(periph_in.spi_data_in, c[1] ? pb_in[6] : pa_in[1]);
         chk(periph_in.spi_cs_in, c[1] ? pc_in[0] : pa_in[3]);
         chk(periph_in.spi_clk_in, c[1] ? pa_in[4] : pd_in[0]);
         chk(periph_in.uart_rx_in, c == 2'h1 ? pa_in[0] : c[1] & !c[0] ? pa_in[5] : pb_in[6]);
         chk(periph_in.external_reset_input, pc_in[2]);
         chk(periph_in.standard_timer1_capture_input, pc_in[2]);
         chk(periph_in.standard_timer1_clock_input, pc_in[1]);
      end
   endtask : t_routes
   task automatic t_master;
      acc(PCDM_ADDR_INSEL, 8'h08, 1'b1);
      @(posedge clk);
      master <= 1'b1;
      cyc(4);
      chk(periph_in.spi_clk_in, pd_in[0]);
      cyc(1);
      chk(periph_in.spi_clk_in, pd_in[0]);
      chk(pa_oe_n[4:3], 8'h00);
      chk(pa_out[4], periph_out.spi_clk_out);
      chk(pa_out[3], periph_out.spi_cs_out);
      chk({pa_oe_n[7:5], pa_oe_n[2:0]}, 8'h3f);
      @(posedge clk);
      master <= 1'b0;
   endtask : t_master
   task automatic t_wake;
      int n;
      acc(PCDM_ADDR_PA_WAKE, 8'h02, 1'b1);
      @(posedge clk);
      ext_lvl <= {8'hff, 19'h0};
      sleep_mode <= 1'b1;
      cyc(6);
      // Pin 1 may wake, pin 2 is masked
      for (int p = 1; p < 3; p++) begin
         n = 0;
         @(posedge clk);
         ext_lvl[19 + p] <= 1'b0;
         repeat (8) begin
            @(posedge clk);
            #1 n += int'(wake_up);
         end
         chk(8'(n), {7'h00, p == 1});
      end
   endtask : t_wake
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("unexpected at %0t: run did not finish", $time);
      wrap_up;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_readback;
      t_codes;
      t_routes({8'h1b, 19'h0});
      t_routes({8'h24, 19'h0});
      t_master;
      t_wake;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      wrap_up;
   end
endmodule : pcdm_pin_mux_test
bind pcdm_pin_mux pcdm_pin_mux_checker i_chk (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
   .periph_out(periph_out), .periph_in(periph_in), .analog_en(analog_en), .pa_in(pa_in),
   .pb_in(pb_in), .pc_out(pc_out), .pc_oe_n(pc_oe_n), .pd_out(pd_out), .pd_oe_n(pd_oe_n));
`default_nettype wire
